/* idts_pkg.sv */
package idts_pkg;
    // Configuration byte offsets
    localparam logic [7:0] PRI_TIM_OFF = 8'h40;
    localparam logic [7:0] SEC_TIM_OFF = 8'h42;
    localparam logic [7:0] SLV_TIM_OFF = 8'h44;
    // Values after reset; bits 11:10 are reserved and read as zero
    localparam logic [15:0] CH_TIM_RST = 16'h0000;
    localparam logic [7:0] SLV_TIM_RST = 8'h00;
    localparam logic [15:0] CH_TIM_WMASK = 16'hF3FF;
    // Channel timing register fields
    localparam int FAST0_BIT = 0;
    localparam int RDY_EN0_BIT = 1;
    localparam int PREFETCH_POST_D0_BIT = 2;
    localparam int DMA_ONLY_FAST_D0_BIT = 3;
    localparam int FAST1_BIT = 4;
    localparam int RDY_EN1_BIT = 5;
    localparam int PREFETCH_POST_D1_BIT = 6;
    localparam int DMA_ONLY_FAST_D1_BIT = 7;
    localparam int RTC_LSB = 8;
    localparam int ISP_LSB = 12;
    localparam int SLAVE_TIMING_ENABLE_BIT = 14;
    // Slave timing register fields
    localparam int SLV_SEC_ISP_LSB = 6;
    localparam int SLV_SEC_RTC_LSB = 4;
    localparam int SLV_PRI_ISP_LSB = 2;
    localparam int SLV_PRI_RTC_LSB = 0;
    // Task file registers and drive select bit
    localparam logic [2:0] DATA_REG = 3'h0;
    localparam logic [2:0] DRVHEAD_REG = 3'h6;
    localparam int DRV_SEL_BIT = 4;
    // Clock counts: code 00 gives the base, each step one fewer
    localparam logic [2:0] ISP_BASE = 3'h5;
    localparam logic [2:0] RTC_BASE = 3'h4;
    typedef enum logic [2:0] {
        TS_IDLE = 3'h1,
        TS_ACTIVE = 3'h2,
        TS_RECOVER = 3'h4
    } idts_tstate_t;
    typedef enum logic [2:0] {
        PATH_COMPAT8 = 3'h1,
        PATH_COMPAT16 = 3'h2,
        PATH_FAST = 3'h4
    } idts_path_t;
endpackage

/* idts_cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module idts_cycle_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Cycle request
    input wire logic start,
    input wire logic [1:0] isp_code,
    input wire logic [1:0] rtc_code,
    input wire logic ready_en,
    // Drive side
    input wire logic iordy,
    output logic io_strobe_n,
    // Status
    output logic busy,
    output logic done
);
    typedef struct packed {
        idts_pkg::idts_tstate_t st;
        logic [2:0] cnt;
        logic [2:0] ready_sample_point;
        logic [2:0] rtc;
        logic ren;
        logic strobe_n;
        logic busy;
        logic done;
    } idts_tim_t;

    idts_tim_t s_r;
    idts_tim_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            idts_pkg::TS_IDLE: begin
                if (start) begin
                    s_nxt.st = idts_pkg::TS_ACTIVE;
                    s_nxt.cnt = 3'h1;
                    s_nxt.strobe_n = 1'b0;
                    s_nxt.busy = 1'b1;
                    s_nxt.ready_sample_point = idts_pkg::ISP_BASE
                                - {1'b0, isp_code};
                    s_nxt.rtc = idts_pkg::RTC_BASE
                                - {1'b0, rtc_code};
                    s_nxt.ren = ready_en;
                end
            end
            idts_pkg::TS_ACTIVE: begin
                // A disabled sample enable reads as ready at the first point
                if (s_r.cnt >= s_r.ready_sample_point && (!s_r.ren || iordy)) begin
                    s_nxt.st = idts_pkg::TS_RECOVER;
                    s_nxt.cnt = 3'h1;
                    s_nxt.strobe_n = 1'b1;
                end else if (s_r.cnt < s_r.ready_sample_point) begin
                    s_nxt.cnt = s_r.cnt + 3'h1;
                end
            end
            idts_pkg::TS_RECOVER: begin
                // Next strobe cannot start before recovery has run out
                if (s_r.cnt >= s_r.rtc) begin
                    s_nxt.st = idts_pkg::TS_IDLE;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + 3'h1;
                end
            end
            default: begin
                s_nxt.st = idts_pkg::TS_IDLE;
                s_nxt.strobe_n = 1'b1;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{st: idts_pkg::TS_IDLE, cnt: 3'h0, ready_sample_point: 3'h0,
                     rtc: 3'h0, ren: 1'b0, strobe_n: 1'b1, busy: 1'b0,
                     done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign io_strobe_n = s_r.strobe_n;
    assign busy = s_r.busy;
    assign done = s_r.done;

    // Cycles the strobe has stood high, for the recovery check
    logic [3:0] gap_r;
    logic [2:0] last_rtc_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_r <= 4'h0;
            last_rtc_r <= 3'h0;
        end else begin
            gap_r <= s_r.strobe_n ? ((gap_r == 4'hF) ? gap_r : gap_r + 4'h1)
                                  : 4'h0;
            if (s_r.st == idts_pkg::TS_RECOVER) begin
                last_rtc_r <= s_r.rtc;
            end
        end
    end

    sequence strobe_starts;
        $fell(io_strobe_n);
    endsequence

    chk_strobe_min_low: assert property (
        @(posedge clk) disable iff (rst)
        strobe_starts |-> !io_strobe_n [*2])
        else $error("strobe released before the earliest sample point");
    chk_forced_ready_ends: assert property (
        @(posedge clk) disable iff (rst)
        (s_r.st == idts_pkg::TS_ACTIVE && s_r.cnt == s_r.ready_sample_point && !s_r.ren)
        |=> io_strobe_n && s_r.st == idts_pkg::TS_RECOVER)
        else $error("forced ready did not end the strobe at the sample point");
    chk_recovery_gap: assert property (
        @(posedge clk) disable iff (rst)
        (strobe_starts and ##0 (last_rtc_r != 3'h0))
        |-> (gap_r > {1'b0, last_rtc_r}))
        else $error("recovery time between strobes too short");
    chk_done_pulse: assert property (@(posedge clk) disable iff (rst)
        done |-> !busy ##1 !done)
        else $error("done is not a single pulse while idle");
endmodule
`default_nettype wire

/* idts_drive_timing.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Keep recovery clocks after last sample; codes 00..11 give 4..1.
// - DMA-only bit gives the drive fast timing for DMA transfers only.
// - Prefetch/post bit: data-port reads prefetched, writes posted.
// - Sample enable clear forces internal ready at the first sample.
// - Drive 0 enable set and selected: ready sampled on every access.
// - Drive 1 qualification ambiguous; drive 1 selection used here.
// - Fast bank bit clear: data port uses 16-bit compatible path.
// - Drive 1 fast bit set, drive 1 selected: data port uses fast bank.
// - Drive 0 fast bit set, drive 0 selected: data port uses fast bank.
// - PIO data accesses get fast timing only while DMA-only bit is zero.
// - Non-data registers always use the 8-bit compatible path.
// - Slave register has no effect unless slave timing enable is set.
// - Secondary slave sample point codes 00..11 give 5..2 clocks.
// - First ready sample comes 5..2 clocks after strobe, by code.
// - Enable clear: both drives use channel values; set: slave's own.
module idts_drive_timing #(
    parameter bit SECONDARY = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration byte port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Host access request
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_dma,
    input wire logic [2:0] acc_reg,
    input wire logic [7:0] acc_wdata,
    output logic acc_done,
    // Timing choice for the current access
    output logic [2:0] access_path,
    output logic prefetch_en,
    output logic post_en,
    output logic drive_sel,
    // Drive cable
    input wire logic iordy,
    output logic io_strobe_n
);
    localparam logic [7:0] CH_LO_OFF =
        SECONDARY ? idts_pkg::SEC_TIM_OFF : idts_pkg::PRI_TIM_OFF;
    localparam logic [7:0] CH_HI_OFF = 8'(CH_LO_OFF + 8'h01);
    localparam int SLV_ISP_LSB =
        SECONDARY ? idts_pkg::SLV_SEC_ISP_LSB : idts_pkg::SLV_PRI_ISP_LSB;
    localparam int SLV_RTC_LSB =
        SECONDARY ? idts_pkg::SLV_SEC_RTC_LSB : idts_pkg::SLV_PRI_RTC_LSB;

    typedef struct packed {
        logic [15:0] ch_tim;
        logic [7:0] slv_tim;
        logic [7:0] rdata;
        logic drv;
        logic pend;
        logic start;
        logic [1:0] ready_sample_point;
        logic [1:0] rtc;
        logic ren;
        idts_pkg::idts_path_t path;
        logic prefetch;
        logic post;
        logic done;
    } idts_main_t;

    idts_main_t s_r;
    idts_main_t s_nxt;

    logic t_busy;
    logic t_done;
    logic taken;
    logic is_data;
    logic fast_cur;
    logic dte_cur;
    logic ie_cur;
    logic ppe_cur;
    logic use_slave;

    assign taken = acc_req && !s_r.pend;
    assign is_data = (acc_reg == idts_pkg::DATA_REG);
    // Per-drive fields picked by the tracked select
    assign fast_cur = s_r.drv ? s_r.ch_tim[idts_pkg::FAST1_BIT]
                              : s_r.ch_tim[idts_pkg::FAST0_BIT];
    assign dte_cur = s_r.drv ? s_r.ch_tim[idts_pkg::DMA_ONLY_FAST_D1_BIT]
                             : s_r.ch_tim[idts_pkg::DMA_ONLY_FAST_D0_BIT];
    // Drive 1 enable qualified by drive 1 being selected
    assign ie_cur = s_r.drv ? s_r.ch_tim[idts_pkg::RDY_EN1_BIT]
                            : s_r.ch_tim[idts_pkg::RDY_EN0_BIT];
    assign ppe_cur = s_r.drv ? s_r.ch_tim[idts_pkg::PREFETCH_POST_D1_BIT]
                             : s_r.ch_tim[idts_pkg::PREFETCH_POST_D0_BIT];
    assign use_slave = s_r.drv && s_r.ch_tim[idts_pkg::SLAVE_TIMING_ENABLE_BIT];

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.done = t_done;
        if (cfg_wr) begin
            if (cfg_addr == CH_LO_OFF) begin
                s_nxt.ch_tim[7:0] = cfg_wdata;
            end else if (cfg_addr == CH_HI_OFF) begin
                s_nxt.ch_tim[15:8] = cfg_wdata & idts_pkg::CH_TIM_WMASK[15:8];
            end else if (cfg_addr == idts_pkg::SLV_TIM_OFF) begin
                s_nxt.slv_tim = cfg_wdata;
            end
        end
        if (cfg_rd) begin
            if (cfg_addr == CH_LO_OFF) begin
                s_nxt.rdata = s_r.ch_tim[7:0];
            end else if (cfg_addr == CH_HI_OFF) begin
                s_nxt.rdata = s_r.ch_tim[15:8];
            end else if (cfg_addr == idts_pkg::SLV_TIM_OFF) begin
                s_nxt.rdata = s_r.slv_tim;
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end
        if (t_done) begin
            s_nxt.pend = 1'b0;
        end
        if (taken) begin
            s_nxt.pend = 1'b1;
            s_nxt.start = 1'b1;
            // Slave register only steers the slave, and only when enabled
            if (use_slave) begin
                s_nxt.ready_sample_point = s_r.slv_tim[SLV_ISP_LSB +: 2];
                s_nxt.rtc = s_r.slv_tim[SLV_RTC_LSB +: 2];
            end else begin
                s_nxt.ready_sample_point = s_r.ch_tim[idts_pkg::ISP_LSB +: 2];
                s_nxt.rtc = s_r.ch_tim[idts_pkg::RTC_LSB +: 2];
            end
            s_nxt.ren = ie_cur;
            if (!is_data) begin
                s_nxt.path = idts_pkg::PATH_COMPAT8;
            end else if (fast_cur && (acc_dma || !dte_cur)) begin
                s_nxt.path = idts_pkg::PATH_FAST;
            end else begin
                s_nxt.path = idts_pkg::PATH_COMPAT16;
            end
            s_nxt.prefetch = is_data && ppe_cur && !acc_write;
            s_nxt.post = is_data && ppe_cur && acc_write;
            // Select change applies from the next access on
            if (acc_write && acc_reg == idts_pkg::DRVHEAD_REG) begin
                s_nxt.drv = acc_wdata[idts_pkg::DRV_SEL_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{ch_tim: idts_pkg::CH_TIM_RST,
                     slv_tim: idts_pkg::SLV_TIM_RST, rdata: 8'h00,
                     drv: 1'b0, pend: 1'b0, start: 1'b0, ready_sample_point: 2'h0,
                     rtc: 2'h0, ren: 1'b0, path: idts_pkg::PATH_COMPAT8,
                     prefetch: 1'b0, post: 1'b0, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    idts_cycle_timer u_timer (
        .clk(clk),
        .rst(rst),
        .start(s_r.start),
        .isp_code(s_r.ready_sample_point),
        .rtc_code(s_r.rtc),
        .ready_en(s_r.ren),
        .iordy(iordy),
        .io_strobe_n(io_strobe_n),
        .busy(t_busy),
        .done(t_done)
    );

    assign cfg_rdata = s_r.rdata;
    assign acc_done = s_r.done;
    assign access_path = s_r.path;
    assign prefetch_en = s_r.prefetch;
    assign post_en = s_r.post;
    assign drive_sel = s_r.drv;

    sequence take_data_pio;
        taken && is_data && !acc_dma;
    endsequence

    chk_nondata_path: assert property (
        @(posedge clk) disable iff (rst)
        (taken && !is_data) |=> access_path == idts_pkg::PATH_COMPAT8)
        else $error("non-data access left the 8-bit compatible path");
    chk_dma_only_pio: assert property (
        @(posedge clk) disable iff (rst)
        (take_data_pio and ##0 dte_cur)
        |=> access_path == idts_pkg::PATH_COMPAT16)
        else $error("PIO data access got fast timing under DMA-only");
    chk_fast_bank_use: assert property (
        @(posedge clk) disable iff (rst)
        (taken && is_data && fast_cur && (acc_dma || !dte_cur))
        |=> access_path == idts_pkg::PATH_FAST)
        else $error("selected drive fast bank not used");
    chk_compat16_use: assert property (
        @(posedge clk) disable iff (rst)
        (taken && is_data && !fast_cur)
        |=> access_path == idts_pkg::PATH_COMPAT16)
        else $error("data access with fast bank off not compatible");
    chk_slave_ignored: assert property (
        @(posedge clk) disable iff (rst)
        (taken && !s_r.ch_tim[idts_pkg::SLAVE_TIMING_ENABLE_BIT])
        |=> s_r.ready_sample_point == $past(s_r.ch_tim[13:12])
            && s_r.rtc == $past(s_r.ch_tim[9:8]))
        else $error("slave timing used while its enable is clear");
    chk_ready_forced: assert property (
        @(posedge clk) disable iff (rst)
        (taken && !ie_cur) |=> !s_r.ren ##1 t_busy)
        else $error("ready sampling not forced for disabled drive");
    chk_drive_track: assert property (
        @(posedge clk) disable iff (rst)
        (taken && acc_write && acc_reg == idts_pkg::DRVHEAD_REG)
        |=> drive_sel == $past(acc_wdata[4]))
        else $error("drive select copy not updated");
    chk_prefetch_off: assert property (
        @(posedge clk) disable iff (rst)
        (taken && !ppe_cur) |=> !prefetch_en && !post_en)
        else $error("prefetch or posting with the enable clear");
endmodule
`default_nettype wire

/* idts_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module idts_drive_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Cable
    input wire logic io_strobe_n,
    output logic iordy,
    // Clocks the drive holds off ready after the strobe falls
    input wire logic [3:0] wait_cycles
);
    logic [3:0] cnt_r;
    // The ready line is pulled up, so it reads ready outside a cycle
    assign iordy = io_strobe_n | (cnt_r >= wait_cycles);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (io_strobe_n) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'hF) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* ide_drive_timing_select_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ide_drive_timing_select_tb_top;
    typedef struct packed {
        logic [2:0] path;
        logic pf;
        logic po;
        logic ds;
        int lo_min;
        int lo_max;
        int rec;
    } idts_exp_t;
    logic clk, rst, cfg_wr, cfg_rd, acc_req, acc_write, acc_dma, acc_done;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, acc_wdata;
    logic [2:0] acc_reg, access_path;
    logic prefetch_en, post_en, drive_sel, iordy, io_strobe_n, rd_seen;
    logic [3:0] drv_wait;
    logic [15:0] tim;
    logic [7:0] slv;
    logic dsel;
    logic [31:0] rv;
    logic [15:0] tv [4] = '{16'h0000, 16'h0011, 16'h0099, 16'h00CC};
    int n_mismatch, checks, seed, lo, rec;
    idts_exp_t aq[$];
    idts_exp_t m_e;
    logic [7:0] cq[$];
    idts_drive_timing #(.SECONDARY(1'b1)) dut (.clk(clk), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .acc_req(acc_req),
        .acc_write(acc_write), .acc_dma(acc_dma), .acc_reg(acc_reg),
        .acc_wdata(acc_wdata), .acc_done(acc_done),
        .access_path(access_path), .prefetch_en(prefetch_en),
        .post_en(post_en), .drive_sel(drive_sel), .iordy(iordy),
        .io_strobe_n(io_strobe_n));
    idts_drive_model drv (.clk(clk), .rst(rst), .io_strobe_n(io_strobe_n),
        .iordy(iordy), .wait_cycles(drv_wait));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic fail(input string m);
        n_mismatch++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task wrap_up();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task cfg_w(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task cfg_r(input logic [7:0] a, input logic [7:0] d);
        cq.push_back(d);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
    endtask
    task set_tim(input logic [15:0] t, input logic [7:0] s);
        tim = t & idts_pkg::CH_TIM_WMASK;
        slv = s;
        cfg_w(idts_pkg::SEC_TIM_OFF, t[7:0]);
        cfg_w(idts_pkg::SEC_TIM_OFF + 8'h01, t[15:8]);
        cfg_w(idts_pkg::SLV_TIM_OFF, s);
    endtask
    task acc(input logic w, input logic dm, input logic [2:0] r,
             input logic [7:0] d);
        idts_exp_t e;
        logic [1:0] ic, rc;
        logic fast, dte;
        int ready_sample_point, wv, k;
        fast = dsel ? tim[4] : tim[0];
        dte = dsel ? tim[7] : tim[3];
        if (r != idts_pkg::DATA_REG) e.path = idts_pkg::PATH_COMPAT8;
        else if (fast && (dm || !dte)) e.path = idts_pkg::PATH_FAST;
        else e.path = idts_pkg::PATH_COMPAT16;
        e.pf = (r == 3'h0) && !w && (dsel ? tim[6] : tim[2]);
        e.po = (r == 3'h0) && w && (dsel ? tim[6] : tim[2]);
        // Slave fields of the secondary channel sit in bits 7:4
        {ic, rc} = (dsel && tim[14]) ? slv[7:4] : {tim[13:12], tim[9:8]};
        ready_sample_point = 5 - ic;
        e.rec = 5 - rc;
        wv = drv_wait;
        e.lo_min = ready_sample_point;
        e.lo_max = ready_sample_point;
        if (dsel ? tim[5] : tim[1]) begin
            e.lo_min = (wv > ready_sample_point) ? wv : ready_sample_point;
            e.lo_max = (wv + 2 > ready_sample_point) ? wv + 2 : ready_sample_point;
        end
        // A drive/head write shows its new select once the access ends
        if (r == idts_pkg::DRVHEAD_REG && w) dsel = d[4];
        e.ds = dsel;
        aq.push_back(e);
        @(negedge clk);
        acc_req = 1'b1;
        acc_write = w;
        acc_dma = dm;
        acc_reg = r;
        acc_wdata = d;
        @(negedge clk);
        acc_req = 1'b0;
        k = 0;
        while (acc_done !== 1'b1 && k < 80) begin
            @(negedge clk);
            k++;
        end
        if (k >= 80) fail("access never finished");
    endtask
    always @(posedge clk) rd_seen <= cfg_rd;
    // Widths are counted on falling edges, where outputs have settled
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            checks++;
            if (cfg_rdata !== cq.pop_front()) fail("config read value");
        end
        if (acc_done === 1'b1) begin
            m_e = aq.pop_front();
            checks++;
            if (access_path !== m_e.path) fail("timing path");
            if ({prefetch_en, post_en} !== {m_e.pf, m_e.po})
                fail("prefetch or posting");
            if (drive_sel !== m_e.ds) fail("drive select");
            if (lo < m_e.lo_min || lo > m_e.lo_max)
                fail("strobe width");
            if (rec != m_e.rec) fail("recovery clocks");
            lo = 0;
            rec = 0;
        end else if (io_strobe_n === 1'b0) lo++;
        else if (lo > 0) rec++;
    end
    initial begin
        #400000;
        fail("watchdog expired");
        wrap_up();
    end
    initial begin
        {cfg_wr, cfg_rd, acc_req, acc_write, acc_dma, dsel} = 6'h00;
        {cfg_addr, cfg_wdata, acc_wdata, slv} = 32'h0;
        {acc_reg, drv_wait, tim} = 23'h0;
        {n_mismatch, checks, lo, rec} = 128'h0;
        seed = 1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cfg_r(idts_pkg::SEC_TIM_OFF, 8'h00);
        cfg_r(idts_pkg::SEC_TIM_OFF + 8'h01, 8'h00);
        cfg_r(idts_pkg::SLV_TIM_OFF, 8'h00);
        cfg_w(idts_pkg::PRI_TIM_OFF, 8'hFF);
        cfg_r(idts_pkg::PRI_TIM_OFF, 8'h00);
        cfg_w(idts_pkg::SEC_TIM_OFF + 8'h01, 8'hFF);
        cfg_r(idts_pkg::SEC_TIM_OFF + 8'h01, 8'hF3);
        $display("test registers done");
        drv_wait = 4'h8;
        for (int c = 0; c < 4; c++) begin
            set_tim({2'b00, c[1:0], 2'b00, c[1:0], 8'h00}, 8'h00);
            acc(1'b0, 1'b0, 3'h0, 8'h00);
        end
        $display("test sample and recovery codes done");
        set_tim(16'h0020, 8'hF0);
        acc(1'b1, 1'b0, 3'h6, 8'h10);
        acc(1'b0, 1'b0, 3'h0, 8'h00);
        acc(1'b1, 1'b0, 3'h0, 8'h00);
        set_tim(16'h4020, 8'hF0);
        acc(1'b0, 1'b0, 3'h0, 8'h00);
        acc(1'b1, 1'b0, 3'h6, 8'h00);
        acc(1'b0, 1'b0, 3'h0, 8'h00);
        set_tim(16'h4002, 8'hF0);
        acc(1'b0, 1'b0, 3'h0, 8'h00);
        $display("test slave timing and ready sampling done");
        drv_wait = 4'h0;
        for (int s = 0; s < 2; s++) begin
            acc(1'b1, 1'b0, 3'h6, {3'h0, s[0], 4'h0});
            for (int i = 0; i < 4; i++) begin
                set_tim(tv[i], 8'h00);
                acc(1'b0, 1'b0, 3'h0, 8'h00);
                acc(1'b1, 1'b1, 3'h0, 8'h00);
                acc(1'b0, 1'b0, 3'h1, 8'h00);
            end
        end
        $display("test timing paths done");
        repeat (40) begin
            rv = $random(seed);
            set_tim(rv[15:0], rv[31:24]);
            drv_wait = {1'b0, rv[18:16]};
            acc(1'b1, 1'b0, 3'h6, rv[27:20]);
            rv = $random(seed);
            acc(rv[0], rv[1], rv[2] ? 3'h0 : rv[5:3], rv[13:6]);
            acc(1'b0, 1'b0, 3'h0, 8'h00);
        end
        $display("test random accesses done");
        wrap_up();
    end
endmodule
`default_nettype wire
